//--- pkg/crf_defs.svh
// offsets, field positions and reset values of the core register group
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_OFS_IND0 7'h00
`define CRF_OFS_IND1 7'h01
`define CRF_OFS_PCL 7'h02
`define CRF_OFS_FLAGS 7'h03
`define CRF_OFS_PTR0L 7'h04
`define CRF_OFS_PTR0H 7'h05
`define CRF_OFS_PTR1L 7'h06
`define CRF_OFS_PTR1H 7'h07
`define CRF_OFS_BANK 7'h08
`define CRF_OFS_WACC 7'h09
`define CRF_OFS_PCLATCH 7'h0a
`define CRF_OFS_INTCTL 7'h0b
`define CRF_NUM_CORE 7'h0c
`define CRF_BIT_TOUT 4
`define CRF_BIT_PDWN 3
`define CRF_BIT_ZERO 2
`define CRF_BIT_NIB 1
`define CRF_BIT_CARRY 0
`define CRF_FLAGS_POR 8'h18
`define CRF_INTCTL_RST 8'h01
`define CRF_PCLATCH_MASK 8'h7f
`define CRF_BANK_MASK 8'h1f
`define CRF_INTCTL_MASK 8'hc1
`endif

//--- pkg/crf_pkg.sv
// types of the core register group
package crf_pkg;
	typedef enum logic [3:0] {
		CRF_OP_NONE = 4'h0,
		CRF_OP_ADD = 4'h1,
		CRF_OP_SUB = 4'h2,
		CRF_OP_LOGIC = 4'h3,
		CRF_OP_CLR = 4'h4,
		CRF_OP_RRC = 4'h5,
		CRF_OP_RLC = 4'h6,
		CRF_OP_MOVE = 4'h7
	} crf_op_t;
	typedef struct packed {
		logic wr_en;
		logic [6:0] addr;
		logic [7:0] wdata;
		crf_op_t op;
		logic [7:0] opa;
		logic [7:0] opb;
	} crf_req_t;
	typedef struct packed {
		logic wdt_clear;
		logic sleep;
		logic wdt_timeout;
		logic warm_reset;
		logic rst_tout;
		logic rst_pdwn;
	} crf_evt_t;
endpackage : crf_pkg

//--- rtl/crf_core_regs.sv
// core register group with arithmetic and reset flag register
//
// Function
// RQ1 - core registers mirrored in every bank
// RQ2 - offsets 0x00..0x0b decode in fixed order
// RQ3 - flag register accepted as any destination
// RQ4 - computed zero/carry flags override written data
// RQ5 - timeout and power-down flags ignore writes
// RQ6 - clear-file on flags: upper zero, zero set
// RQ7 - software prefers flag-neutral ops for flags
// RQ8 - bits seven to five read zero
// RQ9 - timeout flag set: power-up, clear, sleep
// RQ10 - timeout flag cleared on watchdog timeout
// RQ11 - power-down set: power-up, watchdog clear
// RQ12 - power-down cleared by sleep
// RQ13 - zero flag follows zero result
// RQ14 - nibble carry from bit three
// RQ15 - carry out of msb
// RQ16 - subtraction carries mean no borrow
// RQ17 - subtract by adding two's complement
// RQ18 - rotate through carry loads shifted bit
// RQ19 - power-on sets reset flags, clears arithmetic
// RQ20 - carries act as inverted borrows on subtract
// RQ21 - other flag bits store written value
`timescale 1ns/1ns
`default_nettype none
`include "crf_defs.svh"
module crf_core_regs (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input var crf_pkg::crf_req_t REQ,
	input var crf_pkg::crf_evt_t EVT,
	output logic [7:0] RDATA,
	output logic [7:0] ALU_RESULT,
	output logic [7:0] FLAGS,
	output logic [7:0] WORKING_ACCUMULATOR_OUT,
	output logic [7:0] BANK_OUT
);
	import crf_pkg::*;

	// --------------------------------------------------------
	// alu
	// --------------------------------------------------------
	logic [8:0] sum;
	logic [4:0] nsum;
	logic [7:0] opb_eff;
	logic cin;
	logic [7:0] res;
	logic upd_z;
	logic upd_c;
	logic c_new;
	logic dc_new;
	logic [6:0] off;

	always_comb begin
		// subtraction adds the complement so the carries become inverted borrows
		opb_eff = (REQ.op == CRF_OP_SUB) ? ~REQ.opb : REQ.opb; // [RQ17]
		cin = (REQ.op == CRF_OP_SUB); // [RQ16] [RQ20]
		sum = {1'b0, REQ.opa} + {1'b0, opb_eff} + {8'h00, cin};
		nsum = {1'b0, REQ.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
		res = 8'h00;
		upd_z = 1'b0;
		upd_c = 1'b0;
		c_new = 1'b0;
		dc_new = 1'b0;
		unique case (REQ.op)
			CRF_OP_ADD, CRF_OP_SUB: begin
				res = sum[7:0];
				upd_z = 1'b1;
				upd_c = 1'b1;
				c_new = sum[8]; // [RQ15]
				dc_new = nsum[4]; // [RQ14]
			end
			CRF_OP_LOGIC: begin
				res = REQ.opa;
				upd_z = 1'b1;
			end
			CRF_OP_CLR: begin
				res = 8'h00;
				upd_z = 1'b1;
			end
			CRF_OP_RRC: begin
				res = {FLAGS[`CRF_BIT_CARRY], REQ.opa[7:1]};
				upd_c = 1'b1;
				c_new = REQ.opa[0]; // [RQ18]
				dc_new = FLAGS[`CRF_BIT_NIB];
			end
			CRF_OP_RLC: begin
				res = {REQ.opa[6:0], FLAGS[`CRF_BIT_CARRY]};
				upd_c = 1'b1;
				c_new = REQ.opa[7]; // [RQ18]
				dc_new = FLAGS[`CRF_BIT_NIB];
			end
			default: begin
				res = REQ.opa;
			end
		endcase
	end

	// --------------------------------------------------------
	// registers
	// --------------------------------------------------------
	logic [7:0] regs_q [0:11];
	logic [7:0] regs_d [0:11];
	logic [4:0] flags_q;
	logic [4:0] flags_d;
	logic [7:0] alu_q;
	logic [7:0] alu_d;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic wr_core;
	logic wr_flags;
	logic [7:0] fl_wr;

	always_comb begin
		off = REQ.addr; // [RQ1] bank bits are not part of the decode
		wr_core = REQ.wr_en && (off < `CRF_NUM_CORE);
		wr_flags = REQ.wr_en && (off == `CRF_OFS_FLAGS); // [RQ3]
		for (int i = 0; i < 12; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (wr_core && !wr_flags) begin
			regs_d[off[3:0]] = res; // [RQ2]
			if (off == `CRF_OFS_PCLATCH) begin
				regs_d[off[3:0]] = res & `CRF_PCLATCH_MASK;
			end
			if (off == `CRF_OFS_BANK) begin
				regs_d[off[3:0]] = res & `CRF_BANK_MASK;
			end
			if (off == `CRF_OFS_INTCTL) begin
				regs_d[off[3:0]] = res & `CRF_INTCTL_MASK;
			end
		end
		flags_d = flags_q;
		fl_wr = res;
		// an op that computes any arithmetic flag discards all three written bits
		if (wr_flags && !upd_z && !upd_c) begin
			// timeout and power-down keep their value [RQ5], upper bits dropped [RQ8]
			flags_d[`CRF_BIT_ZERO] = fl_wr[`CRF_BIT_ZERO]; // [RQ21]
			flags_d[`CRF_BIT_NIB] = fl_wr[`CRF_BIT_NIB]; // [RQ21]
			flags_d[`CRF_BIT_CARRY] = fl_wr[`CRF_BIT_CARRY]; // [RQ21]
		end
		if (upd_z) begin
			flags_d[`CRF_BIT_ZERO] = (res == 8'h00); // [RQ13] [RQ4] [RQ6]
		end
		if (upd_c) begin
			flags_d[`CRF_BIT_CARRY] = c_new; // [RQ4]
			flags_d[`CRF_BIT_NIB] = dc_new; // [RQ4]
		end
		if (EVT.wdt_clear) begin
			flags_d[`CRF_BIT_TOUT] = 1'b1; // [RQ9]
			flags_d[`CRF_BIT_PDWN] = 1'b1; // [RQ11]
		end
		if (EVT.sleep) begin
			flags_d[`CRF_BIT_TOUT] = 1'b1; // [RQ9]
			flags_d[`CRF_BIT_PDWN] = 1'b0; // [RQ12]
		end
		if (EVT.wdt_timeout) begin
			flags_d[`CRF_BIT_TOUT] = 1'b0; // [RQ10]
		end
		if (EVT.warm_reset) begin
			// arithmetic flags are not reset and still follow an op in the same cycle, cause flags follow the cause
			flags_d[`CRF_BIT_TOUT] = EVT.rst_tout; // [RQ19]
			flags_d[`CRF_BIT_PDWN] = EVT.rst_pdwn; // [RQ19]
		end
		alu_d = res;
		rdata_d = 8'h00;
		if (off == `CRF_OFS_FLAGS) begin
			rdata_d = {3'b000, flags_d}; // [RQ8]
		end else if (off < `CRF_NUM_CORE) begin
			rdata_d = regs_d[off[3:0]];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 12; i++) begin
				regs_q[i] <= 8'h00;
			end
			regs_q[11] <= `CRF_INTCTL_RST;
			flags_q <= 5'(`CRF_FLAGS_POR); // [RQ19]
			alu_q <= 8'h00;
			rdata_q <= 8'h00;
		end else begin
			for (int i = 0; i < 12; i++) begin
				regs_q[i] <= regs_d[i];
			end
			flags_q <= flags_d;
			alu_q <= alu_d;
			rdata_q <= rdata_d;
		end
	end

	assign RDATA = rdata_q;
	assign ALU_RESULT = alu_q;
	assign FLAGS = {3'b000, flags_q};
	assign WORKING_ACCUMULATOR_OUT = regs_q[9];
	assign BANK_OUT = regs_q[8];

	// --------------------------------------------------------
	// assertions
	// --------------------------------------------------------
	a_upper_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N) FLAGS[7:5] == 3'b000) else $error("upper flag bits set"); // [RQ8]
	a_sleep_pd: assert property (@(posedge CLK_SYS) disable iff (!RST_N) EVT.sleep && !EVT.wdt_timeout && !EVT.warm_reset |=> !FLAGS[3] && FLAGS[4]) else $error("sleep flags wrong"); // [RQ12]
	a_watchdog_clear_op_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) EVT.wdt_clear && !EVT.sleep && !EVT.wdt_timeout && !EVT.warm_reset |=> FLAGS[4:3] == 2'b11) else $error("clear flags wrong"); // [RQ9]
	a_timeout_clr: assert property (@(posedge CLK_SYS) disable iff (!RST_N) EVT.wdt_timeout && !EVT.warm_reset |=> !FLAGS[4]) else $error("timeout not cleared"); // [RQ10]
	a_write_prot: assert property (@(posedge CLK_SYS) disable iff (!RST_N) !EVT.wdt_clear && !EVT.sleep && !EVT.wdt_timeout && !EVT.warm_reset |=> $stable(FLAGS[4:3])) else $error("reset flags changed"); // [RQ5]
	a_zero_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N) REQ.op inside {CRF_OP_ADD, CRF_OP_SUB, CRF_OP_LOGIC} |=> FLAGS[2] == (ALU_RESULT == 8'h00)) else $error("zero flag wrong"); // [RQ13]
	a_add_carry: assert property (@(posedge CLK_SYS) disable iff (!RST_N) REQ.op == CRF_OP_ADD |=> FLAGS[0] == $past(({1'b0, REQ.opa} + {1'b0, REQ.opb}) > 9'h0ff)) else $error("carry wrong"); // [RQ15]
	a_sub_borrow: assert property (@(posedge CLK_SYS) disable iff (!RST_N) REQ.op == CRF_OP_SUB |=> FLAGS[0] == $past(REQ.opa >= REQ.opb)) else $error("borrow wrong"); // [RQ16]
	a_nib_borrow: assert property (@(posedge CLK_SYS) disable iff (!RST_N) REQ.op == CRF_OP_SUB |=> FLAGS[1] == $past(REQ.opa[3:0] >= REQ.opb[3:0])) else $error("nibble borrow wrong"); // [RQ14]
	a_rotate_c: assert property (@(posedge CLK_SYS) disable iff (!RST_N) REQ.op == CRF_OP_RRC |=> FLAGS[0] == $past(REQ.opa[0])) else $error("rotate carry wrong"); // [RQ18]
	a_clear_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_N) REQ.op == CRF_OP_CLR && REQ.wr_en && REQ.addr == 7'h03 && !EVT.warm_reset |=> FLAGS[2] && $stable(FLAGS[1:0])) else $error("clear on flags wrong"); // [RQ6]
	a_warm_cause: assert property ( // [RQ19]
		@(posedge CLK_SYS) disable iff (!RST_N)
		EVT.warm_reset |=> FLAGS[4:3] == $past({EVT.rst_tout, EVT.rst_pdwn})
	) else $error("reset cause flags wrong");
	a_rlc_carry: assert property ( // [RQ18]
		@(posedge CLK_SYS) disable iff (!RST_N)
		REQ.op == CRF_OP_RLC |=> FLAGS[0] == $past(REQ.opa[7])
	) else $error("left rotate carry wrong");
	a_add_nibble: assert property ( // [RQ14]
		@(posedge CLK_SYS) disable iff (!RST_N)
		REQ.op == CRF_OP_ADD |=>
		FLAGS[1] == $past(({1'b0, REQ.opa[3:0]} + {1'b0, REQ.opb[3:0]}) > 5'h0f)
	) else $error("nibble carry wrong");
	a_sub_result: assert property ( // [RQ17]
		@(posedge CLK_SYS) disable iff (!RST_N)
		REQ.op == CRF_OP_SUB |=> ALU_RESULT == $past(8'(REQ.opa - REQ.opb))
	) else $error("difference wrong");
	a_flag_store: assert property ( // [RQ21]
		@(posedge CLK_SYS) disable iff (!RST_N)
		REQ.wr_en && REQ.addr == 7'h03 && REQ.op inside {CRF_OP_NONE, CRF_OP_MOVE} |=>
		FLAGS[2:0] == $past(REQ.opa[2:0])
	) else $error("flag write not stored");
	a_bank_width: assert property ( // [RQ2]
		@(posedge CLK_SYS) disable iff (!RST_N)
		BANK_OUT[7:5] == 3'b000
	) else $error("bank selector too wide");
	c_warm: cover property (@(posedge CLK_SYS) EVT.warm_reset);
	c_sub: cover property (@(posedge CLK_SYS) REQ.op == CRF_OP_SUB);
	c_sleep: cover property (@(posedge CLK_SYS) EVT.sleep);
	c_flag_write: cover property (@(posedge CLK_SYS) REQ.wr_en && REQ.addr == 7'h03);
endmodule : crf_core_regs
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the core register group
`timescale 1ns/1ns
`default_nettype none
`include "crf_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	import crf_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	crf_req_t REQ = '0;
	crf_evt_t EVT = '0;
	logic [7:0] RDATA, ALU_RESULT, FLAGS, WORKING_ACCUMULATOR_OUT, BANK_OUT;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h0ed573ab;
	logic [7:0] f, res, rd;
	logic [7:0] regs [12];
	logic vld, rdk;
	crf_req_t r;
	crf_op_t ops [8] = '{CRF_OP_NONE, CRF_OP_ADD, CRF_OP_SUB, CRF_OP_CLR, CRF_OP_RRC,
		CRF_OP_RLC, CRF_OP_MOVE, CRF_OP_LOGIC};
	logic [5:0] evs [6] = '{6'h10, 6'h20, 6'h08, 6'h06, 6'h05, 6'h28};
	always #25 CLK_SYS = ~CLK_SYS;
	crf_core_regs u_crf_core_regs (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ(REQ), .EVT(EVT),
		.RDATA(RDATA), .ALU_RESULT(ALU_RESULT), .FLAGS(FLAGS), .WORKING_ACCUMULATOR_OUT(WORKING_ACCUMULATOR_OUT),
		.BANK_OUT(BANK_OUT));
	// ----------------------------------------
	// expectation helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction : lfsr
	// returns {nibble carry, carry, result}
	function automatic logic [9:0] alu(input crf_op_t o, input logic [7:0] a, b, input logic c);
		logic [8:0] s;
		logic [4:0] n;
		n = 5'h00;
		case (o)
			CRF_OP_ADD: begin
				s = {1'b0, a} + {1'b0, b};
				n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
			end
			CRF_OP_SUB: begin
				s = {1'b0, a} + {1'b0, ~b} + 9'h001;
				n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
			end
			CRF_OP_RRC: s = {a[0], c, a[7:1]};
			CRF_OP_RLC: s = {a[7], a[6:0], c};
			CRF_OP_CLR: s = 9'h000;
			default: s = {c, a};
		endcase
		return {n[4], s};
	endfunction : alu
	function automatic logic [7:0] msk(input logic [6:0] a);
		return (a == 7'h08) ? 8'h1f : (a == 7'h0a) ? 8'h7f : (a == 7'h0b) ? 8'hc1 : 8'hff;
	endfunction : msk
	function automatic crf_req_t mk(input logic w, input logic [6:0] a, input crf_op_t o,
		input logic [7:0] x, y);
		return '{w, a, 8'h00, o, x, y};
	endfunction : mk
	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task do_reset;
		@(posedge CLK_SYS);
		RST_N <= 1'b0;
		REQ <= '0;
		EVT <= '0;
		repeat (4) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		`CHK(FLAGS, 8'h18)
		`CHK(WORKING_ACCUMULATOR_OUT, 8'h00)
		@(posedge CLK_SYS);
		RST_N <= 1'b1;
		f = 8'h18;
		foreach (regs[i]) regs[i] = 8'h00;
		regs[11] = 8'h01;
		vld = 1'b0;
	endtask : do_reset
	// one request a cycle, back to back; the previous one is checked meanwhile
	task run(input crf_req_t q, input crf_evt_t e);
		logic [9:0] v;
		@(posedge CLK_SYS);
		REQ <= q;
		EVT <= e;
		@(negedge CLK_SYS);
		if (vld) begin
			`CHK(FLAGS, f)
			`CHK(FLAGS[1:0], f[1:0])
			`CHK(ALU_RESULT, res)
			`CHK(WORKING_ACCUMULATOR_OUT, regs[9])
			`CHK(BANK_OUT, regs[8])
			if (rdk) `CHK(RDATA, rd)
		end
		v = alu(q.op, q.opa, q.opb, f[0]);
		res = v[7:0];
		if (q.op inside {CRF_OP_ADD, CRF_OP_SUB}) f[2:0] = {res == 8'h00, v[9:8]};
		if (q.op inside {CRF_OP_CLR, CRF_OP_LOGIC}) f[2] = (res == 8'h00);
		if (q.op inside {CRF_OP_RRC, CRF_OP_RLC}) f[0] = v[8];
		if (q.wr_en && q.addr == 7'h03 && q.op inside {CRF_OP_NONE, CRF_OP_MOVE})
			f[2:0] = res[2:0];
		if (q.wr_en && q.addr inside {[7'h04:7'h0b]}) regs[q.addr[3:0]] = res & msk(q.addr);
		if (e.wdt_clear) f[4:3] = 2'b11;
		if (e.sleep) f[4:3] = 2'b10;
		if (e.wdt_timeout) f[4] = 1'b0;
		if (e.warm_reset) f[4:3] = {e.rst_tout, e.rst_pdwn};
		rdk = q.addr >= 7'h03;
		rd = (q.addr == 7'h03) ? f : (q.addr < 7'h0c) ? regs[q.addr[3:0]] : 8'h00;
		vld = 1'b1;
	endtask : run
	task report_and_stop;
		if (error_cnt == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		do_reset();
		run(mk(1'b1, 7'h09, CRF_OP_SUB, 8'h05, 8'h03), '0);
		run(mk(1'b1, 7'h03, CRF_OP_ADD, 8'hff, 8'h01), '0);
		run(mk(1'b0, 7'h03, CRF_OP_SUB, 8'h03, 8'h05), '0);
		run(mk(1'b1, 7'h03, CRF_OP_MOVE, 8'hff, 8'h00), '0);
		run(mk(1'b1, 7'h03, CRF_OP_CLR, 8'h5a, 8'h00), '0);
		run(mk(1'b0, 7'h03, CRF_OP_RRC, 8'h01, 8'h00), '0);
		run(mk(1'b1, 7'h08, CRF_OP_RLC, 8'h80, 8'h00), '0);
		foreach (evs[i]) run(mk(1'b0, 7'h03, CRF_OP_NONE, 8'h00, 8'h00), crf_evt_t'(evs[i]));
		// random traffic, with a reset in mid-run
		for (int k = 0; k < 4000; k++) begin
			if (k == 2500) do_reset();
			seed = lfsr(seed);
			r = mk(seed[8], seed[7] ? {3'h0, seed[3:0]} : seed[6:0], ops[seed[18:16]],
				seed[15:8], seed[31:24]);
			// a rotate into the flag register leaves the written bits ambiguous
			if (r.addr == 7'h03 && r.op inside {CRF_OP_RRC, CRF_OP_RLC}) r.wr_en = 1'b0;
			run(r, (seed[23:21] == 3'h0) ? seed[29:24] : {4'h0, seed[25:24]});
		end
		run('0, '0);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
